/* File: design/irq_mask_pkg.sv */
// Package: register map, field layout and shared types for the DMA irq block
// Functional notes
// RQ1 - One written to set bits 15..8 enables tx threshold interrupt.
// RQ2 - One written to set bits 7..0 enables tx pending interrupt.
// RQ3 - One written to a clear bit disables that interrupt, same layout.
// RQ4 - Both enable registers read current enables; all enables zero after reset.
// RQ5 - Read-only 32-bit input vector reflects the DMA interrupt inputs.
// RQ6 - Read/write 5-bit end-of-interrupt vector field in low bits.
// RQ7 - Rx raw status: threshold flag at bit 8+n, pending at bit n.
// RQ8 - Rx masked status: flags after masking, same bits, zero after reset.
// RQ9 - Tx raw status: threshold flags bits 15..8, pending flags bits 7..0.
// RQ10 - Masked bit is raw AND enable; irq while any masked bit set.
// RQ11 - Zero writes leave enables; reserved bits ignored, read zero. The rx enable at RX_EN_OFS is written whole, so zero bits clear rx enables.
package irq_mask_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAN_N = 8;

  localparam logic [ADDR_W-1:0] TX_STAT_RAW_OFS  = 8'h80;
  localparam logic [ADDR_W-1:0] TX_STAT_MASK_OFS = 8'h84;
  localparam logic [ADDR_W-1:0] TX_EN_SET_OFS    = 8'h88;
  localparam logic [ADDR_W-1:0] TX_EN_CLR_OFS    = 8'h8c;
  localparam logic [ADDR_W-1:0] IN_VECTOR_OFS    = 8'h90;
  localparam logic [ADDR_W-1:0] END_VECTOR_OFS   = 8'h94;
  localparam logic [ADDR_W-1:0] RX_STAT_RAW_OFS  = 8'ha0;
  localparam logic [ADDR_W-1:0] RX_STAT_MASK_OFS = 8'ha4;
  localparam logic [ADDR_W-1:0] RX_EN_OFS        = 8'ha8;

  localparam int THRESH_LSB = 8;
  localparam int PEND_LSB   = 0;
  localparam int END_VEC_W  = 5;

  localparam logic [15:0]          EN_RESET      = 16'h0000;
  localparam logic [END_VEC_W-1:0] END_VEC_RESET = 5'h00;
  localparam logic [DATA_W-1:0]    UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // Threshold flags in the upper byte, pending flags in the lower byte
  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] pend;
  } chan_flags_t;

endpackage

/* File: design/irq_flag_mask.sv */
// Masking of one direction's raw flags by its enable bits
`timescale 1ns/1ps
module irq_flag_mask
  import irq_mask_pkg::*;
(
  // Inputs
  input  wire chan_flags_t raw,
  input  wire chan_flags_t enable,
  // Results
  output chan_flags_t      masked,
  output logic             any
);

  assign masked = raw & enable;  // [RQ10]
  assign any    = |masked;       // [RQ10]

endmodule

/* File: design/dma_channel_irq_mask_status.sv */
// Per-channel DMA interrupt enables, raw and masked status registers
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module dma_channel_irq_mask_status
  import irq_mask_pkg::*;
#(
  parameter int CHANNELS = CHAN_N
)
(
  // Clock and control
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Register port
  input  wire reg_req_t          req,
  output logic [DATA_W-1:0]      rdata,
  // Interrupt sources
  input  wire chan_flags_t       tx_raw,
  input  wire chan_flags_t       rx_raw,
  input  wire logic [DATA_W-1:0] dma_in_vector,
  // Interrupt outputs
  output logic                   irq,
  output logic [END_VEC_W-1:0]   end_vector,
  output logic                   end_vector_strobe
);

  if (CHANNELS != CHAN_N) begin : g_chk
    $error("CHANNELS must equal the fixed register layout width");
  end

  typedef struct packed {
    chan_flags_t              tx_en;
    chan_flags_t              rx_en;
    logic [END_VEC_W-1:0]     eoi;
    logic                     eoi_stb;
    chan_flags_t              rx_masked;
    logic                     irq;
    logic [DATA_W-1:0]        rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  chan_flags_t tx_masked;
  chan_flags_t rx_masked_c;
  logic        tx_any;
  logic        rx_any;

  irq_flag_mask u_tx_mask (
    .raw    (tx_raw),
    .enable (state_reg.tx_en),
    .masked (tx_masked),
    .any    (tx_any)
  );

  irq_flag_mask u_rx_mask (
    .raw    (rx_raw),
    .enable (state_reg.rx_en),
    .masked (rx_masked_c),
    .any    (rx_any)
  );

  // Only the low sixteen bits hold flags; everything above reads zero
  function automatic logic [DATA_W-1:0] widen(input chan_flags_t f);
    widen = {16'h0000, f};  // [RQ11]
  endfunction

  always_comb begin
    state_next         = state_reg;
    state_next.eoi_stb = 1'b0;
    if (req.wr) begin
      unique case (req.addr)
        TX_EN_SET_OFS: begin
          // Thresholds in [15:8], pending in [7:0]
          state_next.tx_en = state_reg.tx_en | req.wdata[15:0];  // [RQ1] [RQ2] [RQ11]
        end
        TX_EN_CLR_OFS: begin
          state_next.tx_en = state_reg.tx_en & ~req.wdata[15:0];  // [RQ3] [RQ11]
        end
        RX_EN_OFS: begin
          state_next.rx_en = req.wdata[15:0];
        end
        END_VECTOR_OFS: begin
          state_next.eoi     = req.wdata[END_VEC_W-1:0];  // [RQ6]
          state_next.eoi_stb = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Registered copy of the rx masked flags; the status read at RX_STAT_MASK_OFS uses unregistered rx_masked_c
    state_next.rx_masked = rx_masked_c;  // [RQ8]
    state_next.irq       = tx_any | rx_any;  // [RQ10]
    state_next.rdata     = UNMAPPED_DATA;
    if (req.rd) begin
      unique case (req.addr)
        TX_STAT_RAW_OFS:  state_next.rdata = widen(tx_raw);  // [RQ9]
        TX_STAT_MASK_OFS: state_next.rdata = widen(tx_masked);
        TX_EN_SET_OFS:    state_next.rdata = widen(state_reg.tx_en);  // [RQ4]
        TX_EN_CLR_OFS:    state_next.rdata = widen(state_reg.tx_en);  // [RQ4]
        IN_VECTOR_OFS:    state_next.rdata = dma_in_vector;  // [RQ5]
        END_VECTOR_OFS: begin
          state_next.rdata = {27'h0000000, state_reg.eoi};  // [RQ6]
        end
        RX_STAT_RAW_OFS:  state_next.rdata = widen(rx_raw);  // [RQ7]
        RX_STAT_MASK_OFS: state_next.rdata = widen(rx_masked_c);  // [RQ8]
        RX_EN_OFS:        state_next.rdata = widen(state_reg.rx_en);
        default:          state_next.rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg.tx_en     <= EN_RESET;  // [RQ4]
      state_reg.rx_en     <= EN_RESET;
      state_reg.eoi       <= END_VEC_RESET;
      state_reg.eoi_stb   <= 1'b0;
      state_reg.rx_masked <= EN_RESET;  // [RQ8]
      state_reg.irq       <= 1'b0;
      state_reg.rdata     <= UNMAPPED_DATA;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign rdata             = state_reg.rdata;
  assign irq               = state_reg.irq;
  assign end_vector        = state_reg.eoi;
  assign end_vector_strobe = state_reg.eoi_stb;

endmodule

/* File: bench/irq_mask_checker.sv */
// Port assertions for the DMA channel irq mask block
`timescale 1ns/1ps
module irq_mask_checker
  import irq_mask_pkg::*;
#(parameter int CHANNELS = CHAN_N)
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 ce,
  input wire reg_req_t             req,
  input wire logic [DATA_W-1:0]    rdata,
  input wire chan_flags_t          tx_raw,
  input wire chan_flags_t          rx_raw,
  input wire logic [DATA_W-1:0]    dma_in_vector,
  input wire logic                 irq,
  input wire logic [END_VEC_W-1:0] end_vector,
  input wire logic                 end_vector_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire       r = ce && req.rd;
  wire       w = ce && req.wr;
  wire [7:0] a = req.addr;
  vec_rd_a: assert property (
    r && a == 8'h90 |=> rdata == $past(dma_in_vector)) else $error("vec");
  rx_raw_a: assert property (
    r && a == 8'ha0 |=> rdata == {16'h0, $past(rx_raw)}) else $error("rx");
  tx_raw_a: assert property (
    r && a == 8'h80 |=> rdata == {16'h0, $past(tx_raw)}) else $error("tx");
  // Masked bits may never exceed the raw flags they came from
  rx_mask_a: assert property (
    r && a == 8'ha4 |=> !(rdata & ~{16'h0, $past(rx_raw)})) else $error("rxm");
  eoi_wr_a: assert property (
    w && a == 8'h94 |=>
    end_vector == $past(req.wdata[4:0]) && end_vector_strobe)
    else $error("eoi");
  hole_rd_a: assert property (r && a == 8'h9c |=> !rdata)
    else $error("hole");
  irq_idle_a: assert property (
    ce && !{tx_raw, rx_raw} |=> !irq) else $error("idle");
  en_set_a: assert property (
    w && a == 8'h88 && req.wdata[0] ##1 ce && tx_raw.pend[0] |=> irq)
    else $error("set");
  cover property (irq);
  cover property (end_vector_strobe);
  cover property (r && a == 8'ha4);
endmodule
bind dma_channel_irq_mask_status irq_mask_checker #(.CHANNELS(CHANNELS))
  i_chk (.*);

/* File: bench/irq_source.sv */
// Far-side source of channel flag levels and the input vector
`timescale 1ns/1ps
module irq_source
  import irq_mask_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         load,
  input  wire logic [63:0]  nxt,
  output chan_flags_t       tx_raw,
  output chan_flags_t       rx_raw,
  output logic [DATA_W-1:0] dma_in_vector
);
  // Levels move only on an edge, as the channel logic would drive them
  always_ff @(posedge clk)
    if (load) {tx_raw, rx_raw, dma_in_vector} <= nxt;
endmodule

/* File: bench/tb.sv */
// Random and corner tests of the DMA channel irq mask block
`timescale 1ns/1ps
module tb;
  import irq_mask_pkg::*;
  logic              clk = 0, nrst = 0, ce = 1, load = 1;
  logic [63:0]       nxt = '1;
  reg_req_t          req = '0;
  logic [DATA_W-1:0] rdata, dma_in_vector, v, d;
  chan_flags_t       tx_raw, rx_raw;
  logic [15:0]       tx, rx, ten, ren;
  logic [4:0]        end_vector, eo;
  logic              irq, end_vector_strobe;
  int                fails = 0, samples_checked = 0, cyc = 0;
  logic [7:0] am [9] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'ha0,
                         8'ha4, 8'h9c};
  initial forever #5 clk = ~clk;
  irq_source i_irq_source (.*);
  dma_channel_irq_mask_status i_dma_channel_irq_mask_status (.*);
  function logic [31:0] ex(logic [7:0] a);
    case (a)
      8'h80: ex = {16'h0, tx};
      8'h84: ex = {16'h0, tx & ten};
      8'h88, 8'h8c: ex = {16'h0, ten};
      8'h90: ex = v;
      8'h94: ex = {27'h0, eo};
      8'ha0: ex = {16'h0, rx};
      8'ha4: ex = {16'h0, rx & ren};
      default: ex = '0;
    endcase
  endfunction
  task chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task test_done;
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [31:0] x);
    @(posedge clk) req <= '{a, x, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
    #1 if (a == 8'h94) chk("stb", end_vector_strobe, 32'h1);
  endtask
  task fl(logic [63:0] x);
    {tx, rx, v} = x;
    @(posedge clk) nxt <= x;
    load <= 1;
    @(posedge clk) load <= 0;
  endtask
  task all_regs;
    foreach (am[i]) begin
      @(posedge clk) req <= '{am[i], 32'h0, 1'b0, 1'b1};
      @(posedge clk) req <= '0;
      #1 chk($sformatf("reg %h", am[i]), rdata, ex(am[i]));
    end
    chk("irq", irq, |{tx & ten, rx & ren});
    chk("eoi", end_vector, eo);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    void'($urandom(32'h5464f91f));
    {tx, rx, v} = '1;
    {ten, ren, eo} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1;
    all_regs;
    // Frozen clock enable must swallow a write
    ce <= 0;
    wr(8'h88, 32'hffff);
    ce <= 1;
    all_regs;
    fl('0);
    all_regs;
    repeat (40) begin
      fl({$urandom, $urandom});
      d = $urandom;
      wr(8'h88, d);
      ten |= d[15:0];
      d = $urandom;
      wr(8'h8c, d);
      ten &= ~d[15:0];
      d = $urandom;
      wr(8'ha8, d);
      ren = d[15:0];
      d = $urandom;
      wr(8'h94, d);
      eo = d[4:0];
      all_regs;
    end
    // Reset in mid-run clears every enable and the end vector
    nrst <= 0;
    repeat (3) @(posedge clk);
    nrst <= 1;
    {ten, ren, eo} = '0;
    all_regs;
    test_done;
  end
endmodule
